// ---- hw/lbt_pkg.sv ----
package lbt_pkg;

   // ahb-lite register map (byte addresses)
   localparam logic [7:0] LBT_OFS_GEN_CFG = 8'h0C;
   localparam logic [7:0] LBT_OFS_RX_TSOFF = 8'h10;
   localparam logic [7:0] LBT_OFS_STROBE = 8'h14;
   localparam logic [7:0] LBT_OFS_PORT_CTL = 8'h18;
   localparam int LBT_ADDR_W = 8;

   // general config field layout
   localparam int LBT_SWAP_BIT = 4;
   localparam int LBT_TMO_LSB = 7;
   localparam int LBT_TMO_MSB = 23;
   localparam int LBT_TMO_W = LBT_TMO_MSB - LBT_TMO_LSB + 1;
   localparam int LBT_OBS_LSB = 24;
   localparam int LBT_OBS_MSB = 26;
   localparam int LBT_OBS_W = LBT_OBS_MSB - LBT_OBS_LSB + 1;
   localparam int LBT_OBS_GROUPS = 8;
   // timeout unit is 128 hclk cycles, i.e. shift by 7
   localparam int LBT_TMO_SHIFT = 7;
   localparam int LBT_PEND_W = LBT_TMO_W + LBT_TMO_SHIFT;

   // rx timestamp offset field
   localparam int LBT_TSOFF_W = 24;

   // strobe timing field layout
   localparam int LBT_A_LSB = 0;
   localparam int LBT_B_LSB = 8;
   localparam int LBT_D_LSB = 16;
   localparam int LBT_E_LSB = 24;
   localparam int LBT_CNT_W = 8;

   // port control (burst mode enable)
   localparam int LBT_BURST_BIT = 0;

   // reset values
   localparam logic [LBT_TMO_W-1:0] LBT_TMO_RST = 17'h00000;
   localparam logic [LBT_OBS_W-1:0] LBT_OBS_RST = 3'h0;
   localparam logic [LBT_TSOFF_W-1:0] LBT_TSOFF_RST = 24'h000000;
   localparam logic [31:0] LBT_STROBE_RST = 32'h00000000;

   // ahb constants
   localparam logic [1:0] LBT_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] LBT_HTRANS_SEQ = 2'h3;

   typedef enum {
      LBT_IDLE,
      LBT_SETUP,
      LBT_STROBE,
      LBT_HOLD,
      LBT_GAP
   } lbt_state_t;

   // one local bus request as it travels from the user port
   typedef struct packed {
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } lbt_req_t;

   // the answer to one request
   typedef struct packed {
      logic timeout;
      logic [31:0] rdata;
   } lbt_rsp_t;

endpackage

// ---- hw/lbt_byteswap.sv ----
`timescale 1ns/1ns
module lbt_byteswap
   import lbt_pkg::*;
#(
   parameter int W = 32
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic swap,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   localparam int NB = W / 8;

   logic [W-1:0] rev;

   // byte k lands in byte NB-1-k when swapping
   genvar k;
   generate
      for (k = 0; k < NB; k++) begin : g_byte
         assign rev[8*k +: 8] = din[8*(NB-1-k) +: 8];
      end
   endgenerate

   // registered so the descriptor path has a clean flop edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dout <= '0;
      end else begin
         dout <= swap ? rev : din;
      end
   end

endmodule

// ---- hw/lbt_core.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// - swap bit 4 byte-reverses tx and rx descriptors; resets to endian strap.
// - abort pending local bus access after timeout field times 128 hclk.
// - timeout field zero disables the timeout; access may pend forever.
// - bits 26:24 pick the observation port group; reset zero.
// - hold queued data block until node timestamp exceeds it by offset.
// - wait bits 7:0 cycles after chip select before output/write enable.
// - after strobe, watch wait/ready up to bits 15:8 cycles.
// - window elapsed without ready: treat slave as ready, finish data phase.
// - window field zero: never assume ready, wait for the slave.
// - hold chip select bits 23:16 cycles after strobe deasserts.
// - burst mode: bits 23:16 also gap between strobes within the burst.
// - keep chip select deasserted bits 31:24 cycles between accesses.
module lbt_core
   import lbt_pkg::*;
#(
   parameter int TS_W = 32,
   parameter int OBS_W = 32
) (
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // endianness strap, sampled after reset release
   input wire logic endian_strap,
   // descriptor byte swap path
   input wire logic [31:0] tx_desc_in,
   output logic [31:0] tx_desc_out,
   input wire logic [31:0] rx_desc_in,
   output logic [31:0] rx_desc_out,
   // observation port
   input wire logic [LBT_OBS_GROUPS*OBS_W-1:0] obs_groups,
   output logic [OBS_W-1:0] obs_out,
   // receive timestamp gate
   input wire logic [TS_W-1:0] node_ts,
   input wire logic [TS_W-1:0] block_ts,
   input wire logic block_valid,
   output logic block_release,
   // local bus request / response
   input wire logic req_valid,
   input wire lbt_req_t req,
   output logic req_ready,
   output logic rsp_valid,
   output lbt_rsp_t rsp,
   // local bus pins
   output logic lb_cs_n,
   output logic lb_oe_n,
   output logic lb_we_n,
   output logic [31:0] lb_addr,
   input wire logic [31:0] lb_data_i,
   output logic [31:0] lb_data_o,
   output logic lb_data_oe_n,
   input wire logic lb_rdy
);

   // ---------------- register storage ----------------
   logic swap_q;
   logic strap_done_q;
   logic [LBT_TMO_W-1:0] tmo_q;
   logic [LBT_OBS_W-1:0] obs_sel_q;
   logic [LBT_TSOFF_W-1:0] tsoff_q;
   logic [31:0] strobe_q;
   logic burst_q;

   // ahb address phase capture
   logic wr_pend_q;
   logic [LBT_ADDR_W-1:0] wr_addr_q;
   logic [31:0] hrdata_q;
   logic ahb_go;
   logic [31:0] rd_mux;

   // a beat is taken only with the bus ready and htrans marking a real transfer;
   // hsize is not looked at, so every beat is handled as a whole word
   assign ahb_go = hsel && hready && (htrans == LBT_HTRANS_NONSEQ || htrans == LBT_HTRANS_SEQ);

   // zero wait state slave, always okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;

   // read mux over the address phase; unmapped reads return zero
   always_comb begin
      rd_mux = '0;
      case (haddr[LBT_ADDR_W-1:0])
         LBT_OFS_GEN_CFG: begin
            rd_mux[LBT_SWAP_BIT] = swap_q;
            rd_mux[LBT_TMO_MSB:LBT_TMO_LSB] = tmo_q;
            rd_mux[LBT_OBS_MSB:LBT_OBS_LSB] = obs_sel_q;
         end
         LBT_OFS_RX_TSOFF: rd_mux[LBT_TSOFF_W-1:0] = tsoff_q;
         LBT_OFS_STROBE: rd_mux = strobe_q;
         LBT_OFS_PORT_CTL: rd_mux[LBT_BURST_BIT] = burst_q;
         default: rd_mux = '0;
      endcase
   end

   // read data is latched at the address phase so it stands in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= '0;
      end else if (ahb_go && !hwrite) begin
         hrdata_q <= rd_mux;
      end
   end

   // write address held over to the data phase, where hwdata arrives
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
      end else begin
         wr_pend_q <= ahb_go && hwrite;
         if (ahb_go) begin
            wr_addr_q <= haddr[LBT_ADDR_W-1:0];
         end
      end
   end

   // swap bit: strap copied once after reset release unless software got there first
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         swap_q <= 1'b0;
         strap_done_q <= 1'b0;
      end else begin
         strap_done_q <= 1'b1;
         if (wr_pend_q && wr_addr_q == LBT_OFS_GEN_CFG) begin
            swap_q <= hwdata[LBT_SWAP_BIT];
         end else if (!strap_done_q) begin
            swap_q <= endian_strap;
         end
      end
   end

   // remaining writable fields
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tmo_q <= LBT_TMO_RST;
         obs_sel_q <= LBT_OBS_RST;
         tsoff_q <= LBT_TSOFF_RST;
         strobe_q <= LBT_STROBE_RST;
         burst_q <= 1'b0;
      end else if (wr_pend_q) begin
         case (wr_addr_q)
            LBT_OFS_GEN_CFG: begin
               tmo_q <= hwdata[LBT_TMO_MSB:LBT_TMO_LSB];
               obs_sel_q <= hwdata[LBT_OBS_MSB:LBT_OBS_LSB];
            end
            LBT_OFS_RX_TSOFF: tsoff_q <= hwdata[LBT_TSOFF_W-1:0];
            LBT_OFS_STROBE: strobe_q <= hwdata;
            LBT_OFS_PORT_CTL: burst_q <= hwdata[LBT_BURST_BIT];
            default: ;
         endcase
      end
   end

   // ---------------- descriptor swap ----------------
   lbt_byteswap #(.W(32)) u_tx_swap (
      .hclk(hclk),
      .hresetn(hresetn),
      .swap(swap_q),
      .din(tx_desc_in),
      .dout(tx_desc_out)
   );

   lbt_byteswap #(.W(32)) u_rx_swap (
      .hclk(hclk),
      .hresetn(hresetn),
      .swap(swap_q),
      .din(rx_desc_in),
      .dout(rx_desc_out)
   );

   // ---------------- observation port ----------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         obs_out <= '0;
      end else begin
         obs_out <= obs_groups[obs_sel_q*OBS_W +: OBS_W];
      end
   end

   // ---------------- rx timestamp gate ----------------
   // modular difference, so the gate survives timestamp wrap
   logic [TS_W-1:0] ts_diff;
   assign ts_diff = node_ts - block_ts;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         block_release <= 1'b0;
      end else begin
         block_release <= block_valid && (ts_diff > TS_W'(tsoff_q));
      end
   end

   // ---------------- local bus strobe sequencer ----------------
   // the four timing counts, one per byte of the strobe register
   logic [LBT_CNT_W-1:0] t_a;
   logic [LBT_CNT_W-1:0] t_b;
   logic [LBT_CNT_W-1:0] t_d;
   logic [LBT_CNT_W-1:0] t_e;
   assign t_a = strobe_q[LBT_A_LSB +: LBT_CNT_W];
   assign t_b = strobe_q[LBT_B_LSB +: LBT_CNT_W];
   assign t_d = strobe_q[LBT_D_LSB +: LBT_CNT_W];
   assign t_e = strobe_q[LBT_E_LSB +: LBT_CNT_W];

   // sequencer state, phase counter and outstanding-time counter
   lbt_state_t state_q;
   lbt_state_t state_d;
   logic [LBT_CNT_W-1:0] cnt_q;
   logic [LBT_PEND_W-1:0] pend_q;
   logic [LBT_PEND_W-1:0] tmo_limit;
   lbt_req_t cur_q;
   logic strobe_done;
   logic tmo_hit;
   logic pending;
   logic take;

   // field counts blocks of 128 clocks, so it sits above seven zero bits
   assign tmo_limit = {tmo_q, LBT_TMO_SHIFT'(0)};
   // only setup and strobe are outstanding; hold and gap are wind-down
   assign pending = (state_q == LBT_SETUP) || (state_q == LBT_STROBE);
   // zero field keeps the timeout quiet for good
   assign tmo_hit = pending && (tmo_q != '0) && (pend_q >= tmo_limit - LBT_PEND_W'(1));
   // ready ends the strobe; an elapsed window only counts when the field is nonzero
   assign strobe_done = lb_rdy || ((t_b != '0) && (cnt_q >= t_b - LBT_CNT_W'(1)));

   // a new request is taken from idle, or straight into the strobe inside a burst
   assign req_ready = (state_q == LBT_IDLE) || (state_q == LBT_HOLD && cnt_q >= t_d && burst_q);
   assign take = req_valid && req_ready;

   // next state; a count of n keeps setup, hold or gap for n+1 cycles; the strobe window lasts n
   always_comb begin
      state_d = state_q;
      case (state_q)
         LBT_IDLE: if (req_valid) state_d = LBT_SETUP;
         LBT_SETUP: begin
            if (tmo_hit) begin
               state_d = LBT_HOLD;
            end else if (cnt_q >= t_a) begin
               state_d = LBT_STROBE;
            end
         end
         LBT_STROBE: if (tmo_hit || strobe_done) state_d = LBT_HOLD;
         LBT_HOLD: begin
            if (cnt_q >= t_d) begin
               if (burst_q && req_valid) begin
                  state_d = LBT_STROBE;
               end else begin
                  state_d = LBT_GAP;
               end
            end
         end
         LBT_GAP: if (cnt_q >= t_e) state_d = LBT_IDLE;
         default: state_d = LBT_IDLE;
      endcase
   end

   // state and phase counter; counter restarts on every state change
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= LBT_IDLE;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         if (state_d != state_q) begin
            cnt_q <= '0;
         end else if (cnt_q != '1) begin
            cnt_q <= cnt_q + LBT_CNT_W'(1);
         end
      end
   end

   // outstanding time of the access; saturates rather than wrapping
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_q <= '0;
      end else if (!pending || take) begin
         pend_q <= '0;
      end else if (pend_q != '1) begin
         pend_q <= pend_q + LBT_PEND_W'(1);
      end
   end

   // request held for the whole access
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cur_q <= '0;
      end else if (take) begin
         cur_q <= req;
      end
   end

   // answer: one pulse when the data phase ends or the access is aborted
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rsp_valid <= 1'b0;
         rsp <= '0;
      end else begin
         rsp_valid <= 1'b0;
         if (tmo_hit) begin
            rsp_valid <= 1'b1;
            rsp.timeout <= 1'b1;
            rsp.rdata <= '0;
         end else if (state_q == LBT_STROBE && strobe_done) begin
            rsp_valid <= 1'b1;
            rsp.timeout <= 1'b0;
            rsp.rdata <= cur_q.write ? 32'h00000000 : lb_data_i;
         end
      end
   end

   // pins; chip select covers setup, strobe and hold
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lb_cs_n <= 1'b1;
         lb_oe_n <= 1'b1;
         lb_we_n <= 1'b1;
         lb_addr <= '0;
         lb_data_o <= '0;
         lb_data_oe_n <= 1'b1;
      end else begin
         lb_cs_n <= !(state_d == LBT_SETUP || state_d == LBT_STROBE || state_d == LBT_HOLD);
         lb_oe_n <= !(state_d == LBT_STROBE && !(take ? req.write : cur_q.write));
         lb_we_n <= !(state_d == LBT_STROBE && (take ? req.write : cur_q.write));
         lb_addr <= take ? req.addr : cur_q.addr;
         lb_data_o <= take ? req.wdata : cur_q.wdata;
         // data driven for writes from setup through hold
         lb_data_oe_n <= !((state_d == LBT_SETUP || state_d == LBT_STROBE || state_d == LBT_HOLD)
            && (take ? req.write : cur_q.write));
      end
   end

endmodule

// ---- verif/lbt_slave_model.sv ----
`timescale 1ns/1ns
module lbt_slave_model (
   input wire logic hclk,
   input wire logic lb_cs_n,
   input wire logic lb_oe_n,
   input wire logic lb_we_n,
   input wire logic [31:0] lb_addr,
   input wire logic [31:0] lb_data_o,
   input wire logic [7:0] dly,
   output logic [31:0] lb_data_i,
   output logic lb_rdy
);
   logic [31:0] mem [16];
   logic [31:0] last_q = 32'h0;
   logic [7:0] n_q = 8'h00;
   wire strb = !lb_cs_n && !(lb_oe_n && lb_we_n);
   // sixteen words, known pattern so the bench can predict reads
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 32'hA5000000 + i;
   end
   // ready after dly strobe cycles; all ones means the slave never answers
   assign lb_rdy = strb && n_q >= dly && dly != 8'hFF;
   // data only while read strobe is low, else a toggling pattern
   assign lb_data_i = (strb && !lb_oe_n) ? mem[lb_addr[5:2]] : ~last_q;
   // strobe age and write capture
   always @(posedge hclk) begin
      n_q <= strb ? n_q + 8'h01 : 8'h00;
      last_q <= lb_data_i;
      if (strb && !lb_we_n) mem[lb_addr[5:2]] <= lb_data_o;
   end
endmodule

// ---- verif/lbt_core_checker.sv ----
`timescale 1ns/1ns
module lbt_core_checker
   import lbt_pkg::*;
#(
   parameter int TS_W = 32,
   parameter int OBS_W = 32
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic [LBT_OBS_GROUPS*OBS_W-1:0] obs_groups,
   input wire logic [OBS_W-1:0] obs_out,
   input wire logic rsp_valid,
   input wire lbt_rsp_t rsp,
   input wire logic lb_cs_n,
   input wire logic lb_oe_n,
   input wire logic lb_we_n,
   input wire logic lb_rdy
);
   logic aw_q, live_q, brst_q;
   logic [7:0] ap_q;
   logic [31:0] cfg_q, stb_q;
   logic [8:0] cnt_q, sl_q, gc_q;
   logic [24:0] pc_q;
   wire strb_n = lb_oe_n & lb_we_n;
   wire [7:0] a_c = stb_q[7:0], b_c = stb_q[15:8], d_c = stb_q[23:16], e_c = stb_q[31:24];
   wire [16:0] t_c = cfg_q[23:7];
   wire [2:0] o_c = cfg_q[26:24];
   // register shadows rebuilt from observed bus writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {aw_q, ap_q, cfg_q, stb_q} <= '0;
      end else begin
         aw_q <= hsel && hready && htrans[1] && hwrite;
         ap_q <= haddr[7:0];
         if (aw_q && ap_q == LBT_OFS_GEN_CFG) cfg_q <= hwdata;
         if (aw_q && ap_q == LBT_OFS_STROBE) stb_q <= hwdata;
      end
   end
   // run lengths of chip select and strobe phases
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {live_q, brst_q, cnt_q, sl_q, pc_q} <= '0;
         gc_q <= 9'h1FF; // saturated: no earlier access to keep apart from
      end else begin
         live_q <= 1'b1;
         brst_q <= !lb_cs_n && (brst_q || !strb_n);
         cnt_q <= (!lb_cs_n && strb_n) ? cnt_q + 9'h001 : 9'h000;
         sl_q <= strb_n ? 9'h000 : sl_q + 9'h001;
         pc_q <= lb_cs_n ? 25'h0000000 : pc_q + 25'h0000001;
         gc_q <= !lb_cs_n ? 9'h000 : (gc_q == 9'h1FF ? gc_q : gc_q + 9'h001);
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_setup;
      $fell(strb_n) |-> cnt_q == (brst_q ? d_c : a_c) + 9'h001;
   endproperty
   a_setup: assert property (p_setup) else $error("strobe after wrong lead time");
   property p_hold;
      $rose(lb_cs_n) |-> cnt_q == d_c + 9'h001;
   endproperty
   a_hold: assert property (p_hold) else $error("chip select hold wrong");
   property p_gap;
      $fell(lb_cs_n) |-> gc_q >= e_c + 9'h002;
   endproperty
   a_gap: assert property (p_gap) else $error("chip select gap too short");
   property p_win;
      !strb_n && b_c != 8'h00 |-> sl_q < {1'b0, b_c};
   endproperty
   a_win: assert property (p_win) else $error("strobe outlived its window");
   property p_rdy_end;
      !strb_n && lb_rdy |=> strb_n;
   endproperty
   a_rdy_end: assert property (p_rdy_end) else $error("ready did not end strobe");
   property p_no_guess;
      $rose(strb_n) && b_c == 8'h00 && t_c == 17'h00000 |-> $past(lb_rdy);
   endproperty
   a_no_guess: assert property (p_no_guess) else $error("strobe ended without ready");
   property p_tmo;
      rsp_valid && rsp.timeout |-> t_c != 17'h00000 && pc_q == {1'b0, t_c, 7'h00};
   endproperty
   a_tmo: assert property (p_tmo) else $error("timeout at wrong time");
   property p_obs;
      live_q |-> obs_out == OBS_W'($past(obs_groups) >> ($past(o_c) * OBS_W));
   endproperty
   a_obs: assert property (p_obs) else $error("observation group wrong");
   c_burst: cover property ($fell(strb_n) && brst_q);
   c_tmo: cover property (rsp_valid && rsp.timeout);
   c_nordy: cover property ($rose(strb_n) && !$past(lb_rdy));
endmodule
bind lbt_core lbt_core_checker #(.TS_W(TS_W), .OBS_W(OBS_W)) u_lbt_core_checker (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hready, .hwdata, .obs_groups, .obs_out, .rsp_valid, .rsp, .lb_cs_n, .lb_oe_n, .lb_we_n, .lb_rdy);

// ---- verif/lbt_core_tb.sv ----
`timescale 1ns/1ns
module lbt_core_tb;
   import lbt_pkg::*;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, block_valid = 1'b0, req_valid = 1'b0;
   logic endian_strap = 1'b1;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, tx_desc_in = 32'h0, rx_desc_in = 32'h0;
   logic [31:0] node_ts = 32'h0, block_ts = 32'h0;
   logic [255:0] obs_groups = '0;
   logic [7:0] dly = 8'h00;
   lbt_req_t req = '0;
   wire [31:0] hrdata, tx_desc_out, rx_desc_out, obs_out, lb_addr, lb_data_i, lb_data_o;
   wire hreadyout, req_ready, rsp_valid, lb_cs_n, lb_oe_n, lb_we_n, lb_rdy, block_release, hresp, lb_data_oe_n;
   wire lbt_rsp_t rsp;
   int failures = 0, compares = 0, seed = 98041;
   logic [32:0] eq[$];
   logic [31:0] mm [16];
   logic [7:0] ra [5] = '{LBT_OFS_GEN_CFG, LBT_OFS_RX_TSOFF, LBT_OFS_STROBE, LBT_OFS_PORT_CTL, 8'h20};
   always #5 hclk = ~hclk;
   lbt_core u_lbt_core (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout),
      .hwdata, .hrdata, .hreadyout, .hresp, .endian_strap, .tx_desc_in, .tx_desc_out, .rx_desc_in,
      .rx_desc_out, .obs_groups, .obs_out, .node_ts, .block_ts, .block_valid, .block_release, .req_valid, .req,
      .req_ready, .rsp_valid, .rsp, .lb_cs_n, .lb_oe_n, .lb_we_n, .lb_addr, .lb_data_i, .lb_data_o,
      .lb_data_oe_n, .lb_rdy);
   lbt_slave_model u_lbt_slave_model (.hclk, .lb_cs_n, .lb_oe_n, .lb_we_n, .lb_addr, .lb_data_o, .dly,
      .lb_data_i, .lb_rdy);
   task automatic summarize();
      if (failures == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   function automatic bit ok(input int s);
      return s == 0 ? hreadyout === 1'b1 : s == 1 ? req_ready === 1'b1 : eq.size() == 0;
   endfunction
   // bounded wait: 0 bus ready, 1 request taken, 2 all answers back
   task automatic wt(input int s);
      int i;
      @(posedge hclk);
      for (i = 0; !ok(s); i++) begin
         if (i > 5000) begin
            failures++;
            summarize();
         end
         @(posedge hclk);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= LBT_HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {24'h000000, a};
      wt(0);
      htrans <= 2'h0;
      hwdata <= d;
      wt(0);
      r = hrdata;
      chk(hresp, 1'b0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(1'b1, a, d, r);
   endtask
   // valid stays up between requests so bursts can chain
   task automatic lb(input logic w, input logic [3:0] i, input logic [31:0] d, input logic tmo);
      req_valid <= 1'b1;
      req <= '{w, {26'h0, i, 2'h0}, d};
      eq.push_back(tmo ? 33'h100000000 : w ? 33'h0 : {1'b0, mm[i]});
      if (w) mm[i] = d;
      wt(1);
   endtask
   // let hold and gap run out before timing is reprogrammed
   task automatic idle();
      req_valid <= 1'b0;
      wt(2);
      repeat (520) @(posedge hclk);
   endtask
   function automatic logic [31:0] bsw(input logic [31:0] x);
      return {x[7:0], x[15:8], x[23:16], x[31:24]};
   endfunction
   function automatic logic rel(input logic v, input logic [31:0] n, b, input logic [23:0] o);
      return v && (n - b) > {8'h00, o};
   endfunction
   // answers arrive in request order
   always @(posedge hclk) begin
      if (hresetn && rsp_valid === 1'b1) chk(rsp, eq.size() ? eq.pop_front() : 33'h1FFFFFFFF);
      // write data driven under a write strobe, released under a read strobe
      if (hresetn && lb_we_n === 1'b0) chk(lb_data_oe_n, 1'b0);
      if (hresetn && lb_oe_n === 1'b0) chk(lb_data_oe_n, 1'b1);
   end
   initial begin
      logic [31:0] r, v;
      for (int i = 0; i < 16; i++) mm[i] = 32'hA5000000 + i;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      foreach (ra[j]) begin
         ahb(1'b0, ra[j], 32'h0, r);
         chk(r, j == 0 ? 32'h10 : 32'h0);
      end
      // every observation group, both swap settings, release around the offset
      for (int k = 0; k < 8; k++) begin
         v = $random(seed);
         wr(LBT_OFS_RX_TSOFF, v);
         ahb(1'b0, LBT_OFS_RX_TSOFF, 32'h0, r);
         chk(r, v & 32'h00FFFFFF);
         wr(LBT_OFS_GEN_CFG, {5'h00, k[2:0], 19'h00000, k[0], 4'h0});
         for (int g = 0; g < 8; g++) obs_groups[g*32+:32] <= $random(seed);
         tx_desc_in <= $random(seed);
         rx_desc_in <= $random(seed);
         r = $random(seed);
         node_ts <= r;
         block_ts <= r - v[23:0] - (k % 3) + 1;
         block_valid <= k != 7;
         repeat (2) @(posedge hclk);
         chk(obs_out, obs_groups[k*32+:32]);
         chk(tx_desc_out, k[0] ? bsw(tx_desc_in) : tx_desc_in);
         chk(rx_desc_out, k[0] ? bsw(rx_desc_in) : rx_desc_in);
         chk(block_release, rel(block_valid, node_ts, block_ts, v[23:0]));
      end
      // random timing, single and burst, write then read back
      for (int k = 0; k < 6; k++) begin
         wr(LBT_OFS_STROBE, k == 0 ? 32'h00FF00FF : $random(seed) & 32'h03030303);
         wr(LBT_OFS_PORT_CTL, k & 1);
         dly <= $random(seed) & 3;
         v = $random(seed);
         lb(1'b1, v[3:0], $random(seed), 1'b0);
         lb(1'b1, v[7:4], $random(seed), 1'b0);
         lb(1'b0, v[3:0], 32'h0, 1'b0);
         lb(1'b0, v[7:4], 32'h0, 1'b0);
         idle();
      end
      // silent slave: timeout, then the window finishing the data phase
      dly <= 8'hFF;
      wr(LBT_OFS_STROBE, 32'h01010001);
      wr(LBT_OFS_GEN_CFG, 32'h00000080);
      lb(1'b0, 4'h3, 32'h0, 1'b1);
      idle();
      wr(LBT_OFS_GEN_CFG, 32'h0);
      wr(LBT_OFS_STROBE, 32'h01010301);
      lb(1'b0, 4'h5, 32'h0, 1'b0);
      lb(1'b1, 4'h6, $random(seed), 1'b0);
      idle();
      // warm reset with the strap low: swap bit must follow it, other fields back to zero
      endian_strap <= 1'b0;
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      ahb(1'b0, LBT_OFS_GEN_CFG, 32'h0, r);
      chk(r, 32'h0);
      summarize();
   end
endmodule
